// ===== cttw_regs.svh
// Opcodes, vectors, flag layout and reset values of the transfer, trap and wait core
`ifndef CTTW_REGS_SVH
`define CTTW_REGS_SVH
// Opcodes handled by this core
`define CTTW_OP_TRAP 8'h83
`define CTTW_OP_ACC2FLG 8'h84
`define CTTW_OP_FLG2ACC 8'h85
`define CTTW_OP_ACC2XL 8'h97
`define CTTW_OP_XL2ACC 8'h9f
`define CTTW_OP_SP2IDX 8'h95
`define CTTW_OP_IDX2SP 8'h94
`define CTTW_OP_WAIT 8'h8f
`define CTTW_OP_TEST_DIR 8'h3d
`define CTTW_OP_TEST_ACC 8'h4d
`define CTTW_OP_TEST_XL 8'h5d
`define CTTW_OP_TEST_IX1 8'h6d
`define CTTW_OP_TEST_IX 8'h7d
`define CTTW_OP_PREFIX 8'h9e
`define CTTW_OP_ADDIX 8'haf
`define CTTW_OP_ADDSP 8'ha7
// Vector addresses
`define CTTW_VEC_TRAP_HI 16'hfffc
`define CTTW_VEC_TRAP_LO 16'hfffd
`define CTTW_VEC_IRQ_HI 16'hfffa
`define CTTW_VEC_IRQ_LO 16'hfffb
`define CTTW_VEC_RST_HI 16'hfffe
`define CTTW_VEC_RST_LO 16'hffff
// Flag byte layout; bits 6 and 5 always read as one
`define CTTW_FLG_V 7
`define CTTW_FLG_HC 4
`define CTTW_FLG_IM 3
`define CTTW_FLG_N 2
`define CTTW_FLG_Z 1
`define CTTW_FLG_C 0
`define CTTW_FLG_FILL 8'h60
// Reset values and small constants
`define CTTW_SP_RST 16'h00ff
`define CTTW_PC_RST 16'h0000
`define CTTW_ONE16 16'h0001
`define CTTW_ZP_HI 8'h00
`define CTTW_LAST_PUSH 3'h4
`endif

// ===== cttw_pkg.sv
// Types shared by the transfer, trap and wait core
`default_nettype none
`include "cttw_regs.svh"
package cttw_pkg;
    typedef struct packed {
        logic v;
        logic hc;
        logic im;
        logic n;
        logic z;
        logic c;
    } cttw_flags_s;
    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } cttw_bus_s;
    typedef enum logic [3:0] {
        ST_RSTH, ST_RSTL, ST_FETCH, ST_PFX, ST_OPER, ST_TESTM,
        ST_PAD, ST_PUSH, ST_VECH, ST_VECL, ST_WAIT
    } cttw_state_e;
    typedef enum logic [2:0] {K_TDIR, K_TIX1, K_TSP1, K_AIX, K_AIS} cttw_opk_e;
    typedef enum logic {V_TRAP, V_IRQ} cttw_vec_e;

    // Flags into the stacked byte layout
    function automatic logic [7:0] cttw_pack(input cttw_flags_s f);
        logic [7:0] b;
        b = `CTTW_FLG_FILL;
        b[`CTTW_FLG_V] = f.v;
        b[`CTTW_FLG_HC] = f.hc;
        b[`CTTW_FLG_IM] = f.im;
        b[`CTTW_FLG_N] = f.n;
        b[`CTTW_FLG_Z] = f.z;
        b[`CTTW_FLG_C] = f.c;
        return b;
    endfunction

    // Byte back into flags; bits 6 and 5 are dropped
    function automatic cttw_flags_s cttw_unpack(input logic [7:0] b);
        return '{v: b[`CTTW_FLG_V], hc: b[`CTTW_FLG_HC], im: b[`CTTW_FLG_IM],
                 n: b[`CTTW_FLG_N], z: b[`CTTW_FLG_Z], c: b[`CTTW_FLG_C]};
    endfunction
endpackage
`default_nettype wire

// ===== cttw_sync2.sv
// Two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module cttw_sync2 #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Pins in, synchronised levels out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_r;

    // Pins idle high, so both stages reset to one
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_r <= '1;
            o_sync <= '1;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ===== cttw_core.sv
// Core executing trap, register transfer, test, wait and signed add instructions
`timescale 1ns/1ps
`default_nettype none
`include "cttw_regs.svh"
module cttw_core
    import cttw_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Internal memory bus, read data valid in the same cycle
    input wire logic [7:0] i_mem_rdata,
    output var cttw_bus_s o_bus,
    // Pins, active low, asynchronous
    input wire logic i_rst_pin_n,
    input wire logic i_irq_pin_n,
    // On-chip service request, same clock
    input wire logic i_periph_irq,
    // Status
    output logic o_cpu_clk_en,
    output logic o_bad_op,
    output logic [7:0] o_acc,
    output logic [15:0] o_index,
    output logic [15:0] o_sp,
    output logic [15:0] o_pc,
    output var cttw_flags_s o_flags
);
    cttw_state_e st_r, st_n;
    cttw_opk_e opk_r, opk_n;
    cttw_vec_e vec_r, vec_n;
    cttw_flags_s fl_r, fl_n;
    cttw_bus_s bus_r, bus_n;
    logic [7:0] a_r, a_n, x_r, x_n, h_r, h_n;
    logic [15:0] sp_r, sp_n, pc_r, pc_n, taddr;
    logic [2:0] push_r, push_n;
    logic hold_r, hold_n, clk_r, clk_n, bad_r, bad_n;
    logic [1:0] pins_s;

    // Pins cross into the core clock before anything reads them
    cttw_sync2 #(.W(2)) u_pin_sync (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_async({i_irq_pin_n, i_rst_pin_n}),
        .o_sync(pins_s)
    );

    // Decode and datapath terms
    wire rst_req = ~pins_s[0];
    wire irq_req = ~pins_s[1] | i_periph_irq;
    wire [7:0] op = i_mem_rdata;
    wire [15:0] hx = {h_r, x_r};
    wire [15:0] imm_sx = {{8{op[7]}}, op};
    wire [15:0] ix_sum = hx + imm_sx;
    wire [15:0] sp_sum = sp_r + imm_sx;
    wire [15:0] zp_addr = {`CTTW_ZP_HI, op};
    wire [15:0] pc_inc = pc_r + `CTTW_ONE16;
    wire [7:0] flag_byte = cttw_pack(fl_r);
    wire testm = (st_r == ST_TESTM);
    wire [7:0] test_val = testm ? op : ((op == `CTTW_OP_TEST_XL) ? x_r : a_r);

    // Stacked byte for each push slot, in stacking order
    function automatic logic [7:0] stack_byte(input logic [2:0] idx, input logic [15:0] pc);
        logic [7:0] b;
        b = flag_byte;
        if (idx == 3'h0) begin
            b = pc[7:0];
        end else if (idx == 3'h1) begin
            b = pc[15:8];
        end else if (idx == 3'h2) begin
            b = x_r;
        end else if (idx == 3'h3) begin
            b = a_r;
        end
        return b;
    endfunction

    // Sequencer; bus outputs are computed one cycle ahead and registered
    always_comb begin
        st_n = st_r;
        opk_n = opk_r;
        vec_n = vec_r;
        fl_n = fl_r;
        a_n = a_r;
        x_n = x_r;
        h_n = h_r;
        sp_n = sp_r;
        pc_n = pc_r;
        push_n = push_r;
        hold_n = hold_r;
        clk_n = clk_r;
        bad_n = 1'b0;
        taddr = hx;
        bus_n = '{addr: pc_r, rd: 1'b0, wr: 1'b0, wdata: 8'h00};
        case (st_r)
            ST_RSTH: begin
                pc_n[15:8] = op;
                st_n = ST_RSTL;
            end
            ST_RSTL: begin
                pc_n[7:0] = op;
                st_n = ST_FETCH;
            end
            ST_FETCH: begin
                pc_n = pc_inc;
                hold_n = 1'b0;
                st_n = ST_FETCH;
                if (op == `CTTW_OP_TRAP) begin
                    // Never gated by the mask
                    vec_n = V_TRAP;
                    push_n = 3'h0;
                    st_n = ST_PUSH;
                end else if (op == `CTTW_OP_ACC2FLG) begin
                    fl_n = cttw_unpack(a_r);
                    hold_n = ~fl_r.im & a_r[`CTTW_FLG_IM];
                    st_n = ST_PAD;
                end else if (op == `CTTW_OP_FLG2ACC) begin
                    a_n = flag_byte;
                end else if (op == `CTTW_OP_ACC2XL) begin
                    x_n = a_r;
                end else if (op == `CTTW_OP_XL2ACC) begin
                    a_n = x_r;
                end else if (op == `CTTW_OP_SP2IDX) begin
                    {h_n, x_n} = sp_r + `CTTW_ONE16;
                    st_n = ST_PAD;
                end else if (op == `CTTW_OP_IDX2SP) begin
                    sp_n = hx - `CTTW_ONE16;
                    st_n = ST_PAD;
                end else if (op == `CTTW_OP_WAIT) begin
                    fl_n.im = 1'b0;
                    clk_n = 1'b0;
                    st_n = ST_WAIT;
                end else if (op == `CTTW_OP_TEST_ACC || op == `CTTW_OP_TEST_XL) begin
                    fl_n.n = test_val[7];
                    fl_n.z = (test_val == 8'h00);
                    fl_n.v = 1'b0;
                end else if (op == `CTTW_OP_TEST_DIR) begin
                    opk_n = K_TDIR;
                    st_n = ST_OPER;
                end else if (op == `CTTW_OP_TEST_IX1) begin
                    opk_n = K_TIX1;
                    st_n = ST_OPER;
                end else if (op == `CTTW_OP_TEST_IX) begin
                    taddr = hx;
                    st_n = ST_TESTM;
                end else if (op == `CTTW_OP_PREFIX) begin
                    st_n = ST_PFX;
                end else if (op == `CTTW_OP_ADDIX) begin
                    opk_n = K_AIX;
                    st_n = ST_OPER;
                end else if (op == `CTTW_OP_ADDSP) begin
                    opk_n = K_AIS;
                    st_n = ST_OPER;
                end else begin
                    bad_n = 1'b1;
                end
            end
            ST_PFX: begin
                // Only the stack-offset test follows the prefix here
                pc_n = pc_inc;
                opk_n = K_TSP1;
                st_n = (op == `CTTW_OP_TEST_IX1) ? ST_OPER : ST_FETCH;
                bad_n = (op != `CTTW_OP_TEST_IX1);
            end
            ST_OPER: begin
                pc_n = pc_inc;
                st_n = ST_TESTM;
                case (opk_r)
                    K_TDIR: taddr = zp_addr;
                    K_TIX1: taddr = hx + zp_addr;
                    K_TSP1: taddr = sp_r + zp_addr;
                    K_AIX: begin
                        {h_n, x_n} = ix_sum;
                        st_n = ST_FETCH;
                    end
                    default: begin
                        sp_n = sp_sum;
                        st_n = ST_FETCH;
                    end
                endcase
            end
            ST_TESTM: begin
                // Memory operand is only read, never written back
                fl_n.n = test_val[7];
                fl_n.z = (test_val == 8'h00);
                fl_n.v = 1'b0;
                st_n = ST_FETCH;
            end
            ST_PUSH: begin
                sp_n = sp_r - `CTTW_ONE16;
                push_n = push_r + 3'h1;
                if (push_r == `CTTW_LAST_PUSH) begin
                    fl_n.im = 1'b1;
                    st_n = ST_VECH;
                end
            end
            ST_VECH: begin
                pc_n[15:8] = op;
                st_n = ST_VECL;
            end
            ST_VECL: begin
                pc_n[7:0] = op;
                st_n = ST_PAD;
            end
            ST_PAD: begin
                st_n = ST_FETCH;
            end
            default: begin
                // Wake logic keeps running while processor clocks are gated
                if (irq_req) begin
                    clk_n = 1'b1;
                    vec_n = V_IRQ;
                    push_n = 3'h0;
                    st_n = ST_PUSH;
                end
            end
        endcase
        // Reset pin restarts from the reset vector, also out of wait
        if (rst_req) begin
            st_n = ST_RSTH;
            sp_n = `CTTW_SP_RST;
            fl_n.im = 1'b1;
            clk_n = 1'b1;
            hold_n = 1'b0;
        end
        // Boundary check; a mask from the transfer takes effect at the next boundary
        if (st_n == ST_FETCH && irq_req && !fl_n.im && !hold_n) begin
            vec_n = V_IRQ;
            push_n = 3'h0;
            st_n = ST_PUSH;
        end
        case (st_n)
            ST_FETCH, ST_PFX, ST_OPER: bus_n = '{pc_n, 1'b1, 1'b0, 8'h00};
            ST_TESTM: bus_n = '{taddr, 1'b1, 1'b0, 8'h00};
            ST_PUSH: bus_n = '{sp_n, 1'b0, 1'b1, stack_byte(push_n, pc_n)};
            ST_VECH: bus_n.addr = (vec_n == V_IRQ) ? `CTTW_VEC_IRQ_HI : `CTTW_VEC_TRAP_HI;
            ST_VECL: bus_n.addr = (vec_r == V_IRQ) ? `CTTW_VEC_IRQ_LO : `CTTW_VEC_TRAP_LO;
            ST_RSTH: bus_n.addr = `CTTW_VEC_RST_HI;
            ST_RSTL: bus_n.addr = `CTTW_VEC_RST_LO;
            default: bus_n = '{pc_n, 1'b0, 1'b0, 8'h00};
        endcase
        if (st_n == ST_VECH || st_n == ST_VECL || st_n == ST_RSTH || st_n == ST_RSTL) begin
            bus_n.rd = 1'b1;
        end
    end

    // State and architectural registers
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= ST_RSTH;
            opk_r <= K_TDIR;
            vec_r <= V_TRAP;
            fl_r <= '{v: 1'b0, hc: 1'b0, im: 1'b1, n: 1'b0, z: 1'b0, c: 1'b0};
            bus_r <= '{addr: `CTTW_VEC_RST_HI, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
            {a_r, x_r, h_r} <= 24'h000000;
            sp_r <= `CTTW_SP_RST;
            pc_r <= `CTTW_PC_RST;
            push_r <= 3'h0;
            {hold_r, bad_r} <= 2'b00;
            clk_r <= 1'b1;
        end else begin
            st_r <= st_n;
            opk_r <= opk_n;
            vec_r <= vec_n;
            fl_r <= fl_n;
            bus_r <= bus_n;
            {a_r, x_r, h_r} <= {a_n, x_n, h_n};
            sp_r <= sp_n;
            pc_r <= pc_n;
            push_r <= push_n;
            {hold_r, bad_r} <= {hold_n, bad_n};
            clk_r <= clk_n;
        end
    end

    // Outputs straight from registers
    assign o_bus = bus_r;
    assign o_cpu_clk_en = clk_r;
    assign o_bad_op = bad_r;
    assign o_acc = a_r;
    assign o_index = hx;
    assign o_sp = sp_r;
    assign o_pc = pc_r;
    assign o_flags = fl_r;

    // Checks; a reset-pin restart in mid-sequence voids them
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_arst_n || rst_req);

    wire fetch_op = (st_r == ST_FETCH);

    property p_trap_pc;
        fetch_op && op == `CTTW_OP_TRAP |=> pc_r == $past(pc_r) + `CTTW_ONE16;
    endproperty
    a_trap_pc: assert property (p_trap_pc) else $error("trap pc not advanced");

    property p_push_order;
        st_r == ST_PUSH && push_r == 3'h0 |-> bus_r.wdata == pc_r[7:0]
            ##1 bus_r.wdata == pc_r[15:8] ##1 bus_r.wdata == x_r
            ##1 bus_r.wdata == a_r ##1 bus_r.wdata == flag_byte;
    endproperty
    a_push_order: assert property (p_push_order) else $error("stack order wrong");

    property p_flag_fill;
        st_r == ST_PUSH && push_r == `CTTW_LAST_PUSH |->
            bus_r.wr && bus_r.wdata[6:5] == 2'b11 && bus_r.wdata[7] == fl_r.v;
    endproperty
    a_flag_fill: assert property (p_flag_fill) else $error("stacked flags bad");

    property p_push_sp;
        st_r == ST_PUSH |-> bus_r.addr == sp_r ##1 sp_r == $past(sp_r) - `CTTW_ONE16;
    endproperty
    a_push_sp: assert property (p_push_sp) else $error("push sp step wrong");

    property p_trap_len;
        fetch_op && op == `CTTW_OP_TRAP |-> ##6 (bus_r.addr == `CTTW_VEC_TRAP_HI && fl_r.im)
            ##3 st_r != ST_PAD && st_r != ST_VECL;
    endproperty
    a_trap_len: assert property (p_trap_len) else $error("trap length wrong");

    property p_acc2flg;
        fetch_op && op == `CTTW_OP_ACC2FLG |=> st_r == ST_PAD
            && flag_byte == ($past(a_r) | `CTTW_FLG_FILL) && a_r == $past(a_r);
    endproperty
    a_acc2flg: assert property (p_acc2flg) else $error("flag load wrong");

    property p_tap_delay;
        // Only a load that sets the mask holds off the request; a cleared mask may take it
        fetch_op && op == `CTTW_OP_ACC2FLG && !fl_r.im && a_r[`CTTW_FLG_IM]
            |-> ##2 st_r != ST_PUSH;
    endproperty
    a_tap_delay: assert property (p_tap_delay) else $error("next op skipped");

    property p_acc2xl;
        fetch_op && op == `CTTW_OP_ACC2XL |=> x_r == $past(a_r) && $stable(fl_r);
    endproperty
    a_acc2xl: assert property (p_acc2xl) else $error("index low copy wrong");

    property p_sp2idx;
        fetch_op && op == `CTTW_OP_SP2IDX |=> hx == $past(sp_r) + `CTTW_ONE16 && $stable(sp_r);
    endproperty
    a_sp2idx: assert property (p_sp2idx) else $error("index from sp wrong");

    property p_idx2sp;
        fetch_op && op == `CTTW_OP_IDX2SP |=> sp_r == $past(hx) - `CTTW_ONE16 && $stable(hx);
    endproperty
    a_idx2sp: assert property (p_idx2sp) else $error("sp from index wrong");

    property p_wait;
        fetch_op && op == `CTTW_OP_WAIT && !irq_req |=> !o_cpu_clk_en && !fl_r.im;
    endproperty
    a_wait: assert property (p_wait) else $error("wait did not gate");

    property p_wake;
        st_r == ST_WAIT && irq_req |=> o_cpu_clk_en && st_r == ST_PUSH && vec_r == V_IRQ;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not serviced");

    property p_addix;
        st_r == ST_OPER && opk_r == K_AIX |=>
            hx == $past(hx) + {{8{$past(op[7])}}, $past(op)} && $stable(fl_r);
    endproperty
    a_addix: assert property (p_addix) else $error("index add wrong");

    c_trap: cover property (fetch_op && op == `CTTW_OP_TRAP ##9 fetch_op);
    c_wake: cover property (st_r == ST_WAIT ##1 st_r == ST_PUSH);
    c_tap_mask: cover property (fetch_op && op == `CTTW_OP_ACC2FLG && !fl_r.im && irq_req);
    c_test_sp: cover property (st_r == ST_OPER && opk_r == K_TSP1 ##1 testm);
endmodule
`default_nettype wire

// ===== cttw_mem_model.sv
// Zero-wait byte memory standing on the far side of the core's internal bus
`timescale 1ns/1ps
`default_nettype none
module cttw_mem_model
    import cttw_pkg::*;
(
    // Clock
    input wire logic i_ref_clk,
    // Bus from the core, read data back
    input wire cttw_bus_s i_bus,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_r = 8'h5a;
    // Unselected cycles show the inverse of the last byte, so stale data never looks valid
    assign o_rdata = i_bus.rd ? mem[i_bus.addr] : ~last_r;
    // Stores land at the edge that carries the strobe; plain always so the bench may preload
    always @(posedge i_ref_clk) begin
        if (i_bus.wr) begin
            mem[i_bus.addr] <= i_bus.wdata;
        end
        last_r <= o_rdata;
    end
endmodule
`default_nettype wire

// ===== cpu_transfer_trap_wait_ops_tb.sv
// Self-checking bench for the trap, transfer, test and wait core
`timescale 1ns/1ps
`default_nettype none
module cpu_transfer_trap_wait_ops_tb
    import cttw_pkg::*;
;
    logic i_ref_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_rst_pin_n = 1'b1;
    logic i_irq_pin_n = 1'b1;
    logic i_periph_irq = 1'b0;
    logic [7:0] rdata, acc, a, fl, r1, r2, r3, r4;
    logic clk_en, bad_op;
    logic [15:0] idx, sp_o, pc_o, hx, sp, pc;
    cttw_bus_s bus;
    cttw_flags_s flg;
    logic [7:0] rm [0:65535];
    logic [15:0] pend[$];
    int fails = 0;
    int num_checks = 0;
    int exp_cyc, n_cyc, exp_bad;
    int bad_total = 0;

    cttw_core u_cttw_core (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_mem_rdata(rdata),
        .o_bus(bus), .i_rst_pin_n(i_rst_pin_n), .i_irq_pin_n(i_irq_pin_n),
        .i_periph_irq(i_periph_irq), .o_cpu_clk_en(clk_en), .o_bad_op(bad_op), .o_acc(acc),
        .o_index(idx), .o_sp(sp_o), .o_pc(pc_o), .o_flags(flg));
    cttw_mem_model u_cttw_mem_model (.i_ref_clk(i_ref_clk), .i_bus(bus), .o_rdata(rdata));

    // Clock at 100 MHz
    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    // Pulses of the unsupported-opcode flag, seen where settled
    always @(negedge i_ref_clk) begin
        if (bad_op === 1'b1) bad_total++;
    end

    task automatic close_out();
        if (fails == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Program bytes go to the memory and to the bench's own copy alike
    task automatic load(input logic [15:0] base, input logic [7:0] q[$]);
        for (int i = 0; i < q.size(); i++) begin
            rm[base + i] = q[i];
            u_cttw_mem_model.mem[base + i] = q[i];
        end
    endtask
    task automatic push(input logic [7:0] b);
        rm[sp] = b;
        pend.push_back(sp);
        sp = sp - 16'h0001;
    endtask
    task automatic trap(input logic [15:0] vec);
        push(pc[7:0]);
        push(pc[15:8]);
        push(hx[7:0]);
        push(a);
        push(fl | 8'h60);
        fl[3] = 1'b1;
        pc = {rm[vec], rm[vec + 16'h0001]};
    endtask
    task automatic tst(input logic [7:0] v);
        fl[7] = 1'b0;
        fl[2] = v[7];
        fl[1] = (v == 8'h00);
    endtask
    // Reference execution of one instruction at the model's program counter
    task automatic exec();
        logic [7:0] op, b1, b2;
        op = rm[pc];
        b1 = rm[pc + 16'h0001];
        b2 = rm[pc + 16'h0002];
        pc = pc + 16'h0001;
        exp_cyc = 1;
        case (op)
            8'h83: begin trap(16'hfffc); exp_cyc = 9; end
            8'h84: begin fl = a | 8'h60; exp_cyc = 2; end
            8'h85: a = fl | 8'h60;
            8'h97: hx[7:0] = a;
            8'h9f: a = hx[7:0];
            8'h95: begin hx = sp + 16'h0001; exp_cyc = 2; end
            8'h94: begin sp = hx - 16'h0001; exp_cyc = 2; end
            8'h4d: tst(a);
            8'h5d: tst(hx[7:0]);
            8'h3d: begin tst(rm[{8'h00, b1}]); pc++; exp_cyc = 3; end
            8'h6d: begin tst(rm[hx + {8'h00, b1}]); pc++; exp_cyc = 3; end
            8'h7d: begin tst(rm[hx]); exp_cyc = 2; end
            8'h9e: begin tst(rm[sp + {8'h00, b2}]); pc += 2; exp_cyc = 4; end
            8'haf: begin hx = hx + {{8{b1[7]}}, b1}; pc++; exp_cyc = 2; end
            8'ha7: begin sp = sp + {{8{b1[7]}}, b1}; pc++; exp_cyc = 2; end
            8'h8f: begin fl[3] = 1'b0; exp_cyc = 0; end
            default: exp_bad++;
        endcase
    endtask
    // Bounded wait for the opcode fetch at an address
    task automatic wait_fetch(input logic [15:0] adr);
        n_cyc = 0;
        do begin
            @(negedge i_ref_clk);
            n_cyc++;
        end while (!(bus.rd === 1'b1 && bus.addr === adr) && n_cyc < 40);
        // Let the negedge pulse counter update before anything is compared
        #1;
    endtask
    // At every fetch the core's state must match the reference
    task automatic step();
        logic [15:0] adr;
        wait_fetch(pc);
        chk(bus.addr, pc);
        if (exp_cyc != 0) chk(n_cyc, exp_cyc);
        chk(acc, a);
        chk(idx, hx);
        chk(sp_o, sp);
        chk(pc_o, pc);
        chk(flg, {fl[7], fl[4:0]});
        chk(clk_en, 1'b1);
        chk(bad_total, exp_bad);
        while (pend.size() > 0) begin
            adr = pend.pop_front();
            chk(u_cttw_mem_model.mem[adr], rm[adr]);
        end
        exec();
    endtask

    initial begin
        #50000;
        fails++;
        close_out();
    end
    initial begin
        void'($urandom(32'hc939ce1f));
        for (int i = 0; i < 65536; i++) begin
            rm[i] = $urandom;
            u_cttw_mem_model.mem[i] = rm[i];
        end
        r1 = $urandom;
        r2 = $urandom;
        r3 = $urandom;
        r4 = $urandom;
        // No program stores at the stack pointer's byte; trap runs under a random mask
        load(16'hfffa, '{8'h03, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00});
        load(16'h0100, '{8'h95, 8'haf, r1, 8'h9f, 8'h4d, 8'h84, 8'h85, 8'h5d, 8'h97, 8'ha7,
            r2, 8'h94, 8'h3d, 8'h40, 8'h7d, 8'h6d, r3, 8'h9e, 8'h6d, r4, 8'h83});
        load(16'h0200, '{8'h8f});
        load(16'h0300, '{8'h00, 8'h85, 8'h97, 8'haf, 8'hf8, 8'h9f, 8'h84, 8'haf, 8'h08,
            8'h9f, 8'h84, 8'h4d, 8'h8f});
        repeat (10) @(posedge i_ref_clk);
        i_arst_n <= 1'b1;
        a = 8'h00;
        hx = 16'h0000;
        sp = 16'h00ff;
        pc = 16'h0100;
        fl = 8'h68;
        exp_cyc = 0;
        exp_bad = 0;
        repeat (16) step();
        @(negedge i_ref_clk);
        chk(clk_en, 1'b0);
        @(posedge i_ref_clk) i_periph_irq <= 1'b1;
        @(posedge i_ref_clk) i_periph_irq <= 1'b0;
        trap(16'hfffa);
        repeat (8) step();
        // Request rises as the flag load is fetched, while the mask goes from clear to set
        @(posedge i_ref_clk) i_periph_irq <= 1'b1;
        step();
        step();
        @(posedge i_ref_clk) i_periph_irq <= 1'b0;
        step();
        @(negedge i_ref_clk);
        chk(clk_en, 1'b0);
        @(posedge i_ref_clk) i_irq_pin_n <= 1'b0;
        trap(16'hfffa);
        step();
        @(posedge i_ref_clk) i_irq_pin_n <= 1'b1;
        @(posedge i_ref_clk) i_rst_pin_n <= 1'b0;
        repeat (6) @(negedge i_ref_clk);
        chk(sp_o, 16'h00ff);
        chk(flg.im, 1'b1);
        @(posedge i_ref_clk) i_rst_pin_n <= 1'b1;
        wait_fetch(16'h0100);
        chk(bus.addr, 16'h0100);
        close_out();
    end
endmodule
`default_nettype wire
